// ==== src/ptl_fifo.sv ====
`timescale 1ns/1ps

module ptl_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  logic [WIDTH-1:0] mem [DEPTH];  // Entries in flip-flops
  logic [AW-1:0]    wr_ptr;       // Next entry to fill
  logic [AW-1:0]    rd_ptr;       // Next entry to drain
  logic [AW:0]      count;        // Entries held
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // Entry write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers; depth must be a power of two so they wrap naturally
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : ptl_fifo

// ==== src/ptl_loader.sv ====
`timescale 1ns/1ps

// Overview of operation
// - Tape groups are four bits, hole is one
// - Load starts by setting counter to start
// - Ten groups assemble one word
// - Space writes assembled word at counter address
// - Counter advances after each stored word
// - Two spaces in a row end loading
// - Counter returns to start, fetch pair
// - Assembly register shifts four per group
// - Each loaded word added into accumulator
// - Single read stores next word at address
// - Order AC replaces transfer register with word
module ptl_loader #(
  parameter int DEPTH = ptl_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                             ref_clk,
  input  wire logic                             resetn,
  // Paper tape reader
  input  wire logic                             tape_valid,
  output logic                                  tape_ready,
  input  wire ptl_pkg::ptl_group_s              tape_group,
  // Magnetic tape drive (one whole word per strobe)
  input  wire logic                             mag_valid,
  input  wire logic [ptl_pkg::WORD_W-1:0]       mag_word,
  // Operator and order control
  input  wire logic                             load_start,
  input  wire logic [ptl_pkg::ADDR_W-1:0]       start_addr,
  input  wire logic                             read_start,
  input  wire logic [ptl_pkg::ADDR_W-1:0]       read_addr,
  input  wire logic                             order_valid,
  input  wire logic [ptl_pkg::ORDER_W-1:0]      order_code,
  // Memory
  output logic                                  mem_wr,
  output ptl_pkg::ptl_mem_wr_s                  mem_wr_req,
  output logic                                  mem_rd,
  output logic [ptl_pkg::ADDR_W-1:0]            mem_rd_addr,
  input  wire logic                             mem_rd_valid,
  input  wire logic [ptl_pkg::WORD_W-1:0]       mem_rd_data,
  // Visible state
  output logic [ptl_pkg::ADDR_W-1:0]            control_counter,
  output logic [ptl_pkg::WORD_W-1:0]            tape_assembly_register,
  output logic [ptl_pkg::WORD_W-1:0]            accumulator_register,
  output logic [ptl_pkg::WORD_W-1:0]            transfer_register,
  output logic [ptl_pkg::WORD_W-1:0]            instruction_pair_register,
  output logic                                  busy,
  output logic                                  load_done
);

  // ****************************************************************
  // Group buffer between reader and assembly register
  // ****************************************************************
  ptl_pkg::ptl_group_s         grp;        // Group at buffer head
  logic                        grp_valid;  // Buffer holds a group
  logic                        grp_take;   // Sequencer consumes group
  ptl_pkg::ptl_state_e         state;      // Sequencer state
  logic [ptl_pkg::ADDR_W-1:0]  load_base;  // Starting address kept
  logic                        last_space; // Previous char was space
  logic                        assembling; // Loading or single read

  ptl_fifo #(
    .WIDTH ($bits(ptl_pkg::ptl_group_s)),
    .DEPTH (DEPTH)
  ) ptl_fifo_i (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (tape_valid),
    .in_ready  (tape_ready),
    .in_data   (tape_group),
    .out_valid (grp_valid),
    .out_ready (grp_take),
    .out_data  (grp)
  );

  // Groups drain only while a tape transfer is in progress, so the
  // buffer fills and stalls the reader between transfers
  assign assembling = (state == ptl_pkg::ST_LOAD) ||
                      (state == ptl_pkg::ST_SREAD);
  assign grp_take   = assembling && grp_valid;
  assign busy       = (state != ptl_pkg::ST_IDLE);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // A space not preceded by a space stores the word; a second space ends loading
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state <= ptl_pkg::ST_IDLE;
    end else begin
      case (state)
        ptl_pkg::ST_IDLE: begin
          if (load_start) begin
            state <= ptl_pkg::ST_LOAD;
          end else if (read_start) begin
            state <= ptl_pkg::ST_SREAD;
          end else if (order_valid &&
                       order_code == ptl_pkg::ORD_MAG_READ) begin
            state <= ptl_pkg::ST_MAG;
          end
        end
        ptl_pkg::ST_LOAD: begin
          if (grp_take && grp.space && last_space) begin
            state <= ptl_pkg::ST_FETCH;
          end
        end
        ptl_pkg::ST_FETCH: begin
          if (mem_rd_valid) begin
            state <= ptl_pkg::ST_IDLE;
          end
        end
        ptl_pkg::ST_SREAD: begin
          if (grp_take && grp.space && !last_space) begin
            state <= ptl_pkg::ST_IDLE;
          end
        end
        ptl_pkg::ST_MAG: begin
          if (mag_valid) begin
            state <= ptl_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= ptl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Tape assembly register and space tracking
  // ****************************************************************
  // Each group shifts in four places at the low end, so the first
  // group of a word ends in the top four bits
  // Ten shifts replace every bit, so the last ten groups form the word;
  // a space leaves the register alone so it can be stored
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tape_assembly_register <= ptl_pkg::WORD_RST;
    end else if (grp_take && !grp.space) begin
      tape_assembly_register <= {tape_assembly_register[
        ptl_pkg::WORD_W-ptl_pkg::GROUP_W-1:0], grp.bits};
    end
  end

  // Space tracking: data clears it, space sets it; starts clear
  always_ff @(posedge ref_clk) begin
    if (!resetn || state == ptl_pkg::ST_IDLE) begin
      last_space <= 1'b0;
    end else if (grp_take) begin
      last_space <= grp.space;
    end
  end

  // ****************************************************************
  // Control counter
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      control_counter <= ptl_pkg::ADDR_RST;
      load_base       <= ptl_pkg::ADDR_RST;
    end else if (state == ptl_pkg::ST_IDLE && load_start) begin
      control_counter <= start_addr;
      load_base       <= start_addr;
    end else if (state == ptl_pkg::ST_LOAD && grp_take &&
                 grp.space) begin
      if (last_space) begin
        control_counter <= load_base;
      end else begin
        control_counter <= control_counter +
                           ptl_pkg::ADDR_W'(1);
      end
    end
  end

  // ****************************************************************
  // Memory write on word-ending space
  // ****************************************************************
  // A space directly after a space stores nothing
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mem_wr          <= 1'b0;
      mem_wr_req.addr <= ptl_pkg::ADDR_RST;
      mem_wr_req.data <= ptl_pkg::WORD_RST;
    end else begin
      mem_wr <= assembling && grp_take && grp.space && !last_space;
      if (assembling && grp_take && grp.space && !last_space) begin
        mem_wr_req.data <= tape_assembly_register;
        mem_wr_req.addr <= (state == ptl_pkg::ST_LOAD) ?
                           control_counter : read_addr;
      end
    end
  end

  // ****************************************************************
  // Checksum into the accumulator
  // ****************************************************************
  // Not cleared at load start: the sum adds to what is there
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      accumulator_register <= ptl_pkg::WORD_RST;
    end else if (state == ptl_pkg::ST_LOAD && grp_take &&
                 grp.space && !last_space) begin
      accumulator_register <= accumulator_register +
                              tape_assembly_register;
    end
  end

  // ****************************************************************
  // Magnetic tape word into the transfer register
  // ****************************************************************
  // Tape words are assumed spaced by the writing program
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      transfer_register <= ptl_pkg::WORD_RST;
    end else if (state == ptl_pkg::ST_MAG && mag_valid) begin
      transfer_register <= mag_word;
    end
  end

  // ****************************************************************
  // First instruction pair fetch after loading
  // ****************************************************************
  assign mem_rd      = (state == ptl_pkg::ST_FETCH);
  assign mem_rd_addr = control_counter;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      instruction_pair_register <= ptl_pkg::WORD_RST;
      load_done                 <= 1'b0;
    end else begin
      load_done <= (state == ptl_pkg::ST_FETCH) && mem_rd_valid;
      if (state == ptl_pkg::ST_FETCH && mem_rd_valid) begin
        instruction_pair_register <= mem_rd_data;
      end
    end
  end

endmodule : ptl_loader

// ==== src/ptl_pkg.sv ====
package ptl_pkg;

  // ****************************************************************
  // Word and tape geometry
  // ****************************************************************
  localparam int WORD_W      = 40;  // Memory word width
  localparam int GROUP_W     = 4;   // Bits per transverse tape group
  localparam int GROUPS_WORD = 10;  // Groups that make one word
  localparam int ADDR_W      = 12;  // Address field width
  localparam int HALF_W      = 20;  // One instruction of a pair
  localparam int ORDER_W     = 8;   // Order field width
  localparam int FIFO_DEPTH  = 16;  // Tape group buffer depth
  localparam int CNT_W       = 4;   // Group counter width

  // Magnetic tape read order code
  localparam logic [ORDER_W-1:0] ORD_MAG_READ = 8'hAC;
  // Reset values
  localparam logic [WORD_W-1:0]  WORD_RST     = 40'h00_0000_0000;
  localparam logic [ADDR_W-1:0]  ADDR_RST     = 12'h000;
  localparam logic [CNT_W-1:0]   CNT_RST      = 4'h0;
  localparam logic [CNT_W-1:0]   CNT_LAST     = 4'h9;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // One tape character: a data group or the word-ending space
  typedef struct packed {
    logic               space;
    logic [GROUP_W-1:0] bits;
  } ptl_group_s;

  // One memory write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } ptl_mem_wr_s;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_SPACE = 3'b010,
    ST_FETCH = 3'b011,
    ST_SREAD = 3'b100,
    ST_MAG   = 3'b101
  } ptl_state_e;

endpackage : ptl_pkg

// ==== tb/ptl_loader_monitor.sv ====
`timescale 1ns/1ps

// ************************************************************
// Port checker
// ************************************************************
module ptl_loader_monitor (
  // Clock and reset
  input wire logic                        ref_clk,
  input wire logic                        resetn,
  // Requests
  input wire logic                        load_start,
  input wire logic [ptl_pkg::ADDR_W-1:0]  start_addr,
  input wire logic                        read_start,
  input wire logic [ptl_pkg::ADDR_W-1:0]  read_addr,
  input wire logic                        order_valid,
  input wire logic [ptl_pkg::ORDER_W-1:0] order_code,
  input wire logic                        mag_valid,
  input wire logic [ptl_pkg::WORD_W-1:0]  mag_word,
  // Memory and state
  input wire logic                        tape_ready,
  input wire logic                        mem_wr,
  input wire ptl_pkg::ptl_mem_wr_s        mem_wr_req,
  input wire logic                        mem_rd,
  input wire logic [ptl_pkg::ADDR_W-1:0]  mem_rd_addr,
  input wire logic [ptl_pkg::WORD_W-1:0]  mem_rd_data,
  input wire logic [ptl_pkg::ADDR_W-1:0]  control_counter,
  input wire logic [ptl_pkg::WORD_W-1:0]  accumulator_register,
  input wire logic [ptl_pkg::WORD_W-1:0]  transfer_register,
  input wire logic [ptl_pkg::WORD_W-1:0]  instruction_pair_register,
  input wire logic                        busy,
  input wire logic                        load_done
);
  logic                       loading;   // Bootstrap load under way
  logic                       mag_wait;  // Order AC waiting for a word
  logic [ptl_pkg::ADDR_W-1:0] start_q;   // Start address of the load

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Track which operation owns the port; load wins over the rest
  always_ff @(posedge ref_clk) begin
    if (!resetn) loading <= 1'b0;
    else if (load_start && !busy) loading <= 1'b1;
    else if (load_done) loading <= 1'b0;
  end
  always_ff @(posedge ref_clk) begin
    if (load_start && !busy) start_q <= start_addr;
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) mag_wait <= 1'b0;
    else if (order_valid && !busy && !load_start && !read_start &&
             order_code == ptl_pkg::ORD_MAG_READ) mag_wait <= 1'b1;
    else if (mag_valid) mag_wait <= 1'b0;
  end

  a_load_start: assert property (load_start && !busy |=>
    control_counter == $past(start_addr)) else $error("start address");
  a_wr_count: assert property (loading && mem_wr |->
    control_counter == mem_wr_req.addr + 12'h001) else $error("counter");
  a_acc_sum: assert property (loading && mem_wr |->
    accumulator_register == $past(accumulator_register) + mem_wr_req.data)
    else $error("accumulator sum");
  a_wr_pulse: assert property (mem_wr |=> !mem_wr)
    else $error("write pulse");
  a_fetch_addr: assert property (mem_rd && loading |->
    control_counter == start_q && mem_rd_addr == start_q)
    else $error("fetch");
  a_pair_load: assert property (load_done |->
    instruction_pair_register == $past(mem_rd_data)) else $error("pair");
  a_read_dest: assert property (mem_wr && !loading |->
    mem_wr_req.addr == read_addr) else $error("read address");
  a_mag_word: assert property (mag_wait && mag_valid |=>
    transfer_register == $past(mag_word)) else $error("transfer word");

  c_write: cover property (mem_wr);
  c_full: cover property (!tape_ready);
  c_done: cover property (load_done);
endmodule : ptl_loader_monitor

bind ptl_loader ptl_loader_monitor ptl_loader_monitor_i (
  .ref_clk(ref_clk), .resetn(resetn), .load_start(load_start),
  .start_addr(start_addr), .read_start(read_start),
  .read_addr(read_addr), .order_valid(order_valid),
  .order_code(order_code), .mag_valid(mag_valid), .mag_word(mag_word),
  .tape_ready(tape_ready), .mem_wr(mem_wr), .mem_wr_req(mem_wr_req),
  .mem_rd(mem_rd), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
  .control_counter(control_counter),
  .accumulator_register(accumulator_register),
  .transfer_register(transfer_register),
  .instruction_pair_register(instruction_pair_register),
  .busy(busy), .load_done(load_done));

// ==== tb/ptl_loader_tb.sv ====
`timescale 1ns/1ps

module ptl_loader_tb;
  logic ref_clk = 1'b0, resetn = 1'b0;
  logic tape_valid, tape_ready, mag_valid, mem_wr, mem_rd, busy, done;
  logic load_start = 0, read_start = 0, order_valid = 0, rd_valid = 0;
  logic [11:0] start_addr = 0, read_addr = 0, cc, rd_addr;
  logic [7:0]  order_code = 0;
  logic [39:0] mag_word, rd_data = 0, asm_r, acc, xfer, pair;
  logic [39:0] mem [0:4095];
  logic [11:0] wa[$];  // Logged write addresses
  logic [39:0] wd[$];  // Logged write data
  ptl_pkg::ptl_group_s  tape_group;
  ptl_pkg::ptl_mem_wr_s wr_req;
  int n_mismatch = 0, n_tests = 0;

  always #5 ref_clk = ~ref_clk;

  ptl_loader #(.DEPTH(16)) ptl_loader_i (.ref_clk(ref_clk),
    .resetn(resetn), .tape_valid(tape_valid), .tape_ready(tape_ready),
    .tape_group(tape_group), .mag_valid(mag_valid), .mag_word(mag_word),
    .load_start(load_start), .start_addr(start_addr),
    .read_start(read_start), .read_addr(read_addr),
    .order_valid(order_valid), .order_code(order_code), .mem_wr(mem_wr),
    .mem_wr_req(wr_req), .mem_rd(mem_rd), .mem_rd_addr(rd_addr),
    .mem_rd_valid(rd_valid), .mem_rd_data(rd_data),
    .control_counter(cc), .tape_assembly_register(asm_r),
    .accumulator_register(acc), .transfer_register(xfer),
    .instruction_pair_register(pair), .busy(busy), .load_done(done));

  ptl_reader ptl_reader_i (.ref_clk(ref_clk), .tape_ready(tape_ready),
    .tape_valid(tape_valid), .tape_group(tape_group),
    .mag_valid(mag_valid), .mag_word(mag_word));

  // Memory: log writes, answer fetches at the next falling edge
  always @(posedge ref_clk) if (mem_wr === 1'b1) begin
    wa.push_back(wr_req.addr);
    wd.push_back(wr_req.data);
    mem[wr_req.addr] = wr_req.data;
  end
  always @(negedge ref_clk) begin
    rd_valid = mem_rd;
    rd_data = (mem_rd === 1'b1) ? mem[rd_addr] : ~rd_data;
  end

  task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Ten groups, first one in the top bits, then the ending space
  task automatic word(input logic [39:0] w);
    for (int i = 0; i < 10; i++)
      ptl_reader_i.push({1'b0, w[39-4*i -: 4]});
    ptl_reader_i.push({1'b1, 4'h5});
  endtask : word

  task automatic wait_idle();
    for (int i = 0; i < 800 && busy !== 1'b0; i++) @(negedge ref_clk);
    check("busy", busy, 0);
  endtask : wait_idle

  // Full buffer refuses; two words load, pair fetched from start
  task automatic t_load();
    word(40'h12_3456_789A);
    word(40'hF0_0F5A_A5C3);
    ptl_reader_i.push({1'b1, 4'h0});
    repeat (24) @(negedge ref_clk);
    check("ready", tape_ready, 0);
    start_addr = 12'h010;
    load_start = 1'b1;
    @(negedge ref_clk);
    load_start = 1'b0;
    for (int i = 0; i < 800 && done !== 1'b1; i++) @(negedge ref_clk);
    check("done", done, 1);
    check("wr0", {wa[0], wd[0]}, 52'h010_1234_5678_9A);
    check("wr1", {wa[1], wd[1]}, 52'h011_F00F_5AA5_C3);
    check("writes", wa.size(), 2);
    check("counter", cc, 12'h010);
    check("pair", pair, 40'h12_3456_789A);
    check("acc", acc, 40'h02_43B1_1E5D);
    wait_idle();
  endtask : t_load

  // Eleven groups: oldest falls off; accumulator left alone
  task automatic t_sread();
    wa.delete();
    wd.delete();
    ptl_reader_i.push({1'b0, 4'h7});
    word(40'hA5_0000_FFFF);
    read_addr = 12'h123;
    @(negedge ref_clk);
    read_start = 1'b1;
    @(negedge ref_clk);
    read_start = 1'b0;
    wait_idle();
    // The write strobe stands in the first idle cycle; it is logged at the edge after
    @(negedge ref_clk);
    check("nwr", wa.size(), 1);
    check("rd", {wa[0], wd[0]}, 52'h123_A500_00FF_FF);
    check("asm", asm_r, 40'hA5_0000_FFFF);
    check("acc", acc, 40'h02_43B1_1E5D);
  endtask : t_sread

  // Word before the order is ignored; first word after it is kept
  task automatic t_mag();
    ptl_reader_i.mag_send(40'h11_1111_1111);
    order_code = 8'hAB;
    order_valid = 1'b1;
    @(negedge ref_clk);
    order_code = 8'hAC;
    check("busy", busy, 0);
    @(negedge ref_clk);
    order_valid = 1'b0;
    ptl_reader_i.mag_send(40'hC3_5A00_FF69);
    ptl_reader_i.mag_send(40'h22_2222_2222);
    wait_idle();
    check("xfer", xfer, 40'hC3_5A00_FF69);
  endtask : t_mag

  task automatic final_report();
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    check("rst", {tape_ready, busy, cc, acc},
          {1'b1, 1'b0, 12'h000, 40'h00_0000_0000});
    t_load();
    t_sread();
    t_mag();
    final_report();
  end
endmodule : ptl_loader_tb

// ==== tb/ptl_reader.sv ====
`timescale 1ns/1ps

// ************************************************************
// Reader and drive model
// ************************************************************
module ptl_reader (
  // Clock
  input  wire logic                   ref_clk,
  // Paper tape side
  input  wire logic                   tape_ready,
  output logic                        tape_valid,
  output ptl_pkg::ptl_group_s         tape_group,
  // Magnetic tape side
  output logic                        mag_valid,
  output logic [ptl_pkg::WORD_W-1:0]  mag_word
);
  ptl_pkg::ptl_group_s q[$];  // Characters still on the tape
  logic                took;   // Head taken at the last edge

  initial begin
    tape_valid = 1'b0;
    tape_group = '0;
    mag_valid  = 1'b0;
    mag_word   = '0;
    took       = 1'b0;
  end

  // Offer held until the edge that sees ready high
  always @(posedge ref_clk) took = tape_valid && tape_ready;

  // Change only after the falling edge; idle lines toggle
  always @(negedge ref_clk) begin
    if (took) void'(q.pop_front());
    took = 1'b0;
    tape_valid = (q.size() != 0);
    tape_group = (q.size() != 0) ? q[0] : ~tape_group;
  end

  // Queue one tape character
  task automatic push(input ptl_pkg::ptl_group_s g);
    q.push_back(g);
  endtask : push

  // One whole word per strobe, a gap after it
  task automatic mag_send(input logic [ptl_pkg::WORD_W-1:0] w);
    @(negedge ref_clk);
    mag_valid = 1'b1;
    mag_word  = w;
    @(negedge ref_clk);
    mag_valid = 1'b0;
    mag_word  = ~w;
    repeat (4) @(negedge ref_clk);
  endtask : mag_send
endmodule : ptl_reader
